// ==== inc/dci_pkg.sv ====
// constants for the disk cable interface controller
// assumes a 20 MHz controller clock and a plain strobe register port
package dci_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_NS     = 50;
	localparam int unsigned TAG_NS     = 1000;
	localparam int unsigned TAG_CYC    = (TAG_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BLINK_MS   = 250;
	localparam int unsigned BLINK_CYC  = BLINK_MS * (1000000 / CLK_NS);
	localparam int unsigned TAG_CNT_W  = 5;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CFG    = 8'h00;
	localparam logic [7:0] OFS_SEL    = 8'h04;
	localparam logic [7:0] OFS_CYL    = 8'h08;
	localparam logic [7:0] OFS_HEAD   = 8'h0C;
	localparam logic [7:0] OFS_CTLW   = 8'h10;
	localparam logic [7:0] OFS_STAT   = 8'h14;
	localparam logic [7:0] OFS_RDWORD = 8'h18;
	localparam logic [7:0] OFS_WRWORD = 8'h1C;
	localparam logic [7:0] OFS_SECT   = 8'h20;

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	localparam int unsigned CFG_TEST_DONE = 0;
	localparam int unsigned CFG_TEST_OK   = 1;
	localparam int unsigned CFG_DRV_FOUND = 2;
	localparam int unsigned CFG_DUAL_PORT = 3;
	localparam int unsigned CFG_W         = 4;
	localparam logic [3:0]  CFG_RST       = 4'h0;

	// ----------------------------------------------------------------
	// select register: unit number in [3:0], radial port in [5:4]
	// ----------------------------------------------------------------
	localparam int unsigned SEL_PORT_LO = 4;
	localparam int unsigned SEL_W       = 6;

	// ----------------------------------------------------------------
	// control word under tag 3, plus the hold bit for tag 3 itself
	// ----------------------------------------------------------------
	localparam int unsigned CW_WRITE_GATE = 0;
	localparam int unsigned CW_READ_GATE  = 1;
	localparam int unsigned CW_OFS_PLUS   = 2;
	localparam int unsigned CW_OFS_MINUS  = 3;
	localparam int unsigned CW_FAULT_CLR  = 4;
	localparam int unsigned CW_AM_ENABLE  = 5;
	localparam int unsigned CW_RTZ        = 6;
	localparam int unsigned CW_STB_EARLY  = 7;
	localparam int unsigned CW_STB_LATE   = 8;
	localparam int unsigned CW_RELEASE    = 9;
	localparam int unsigned CW_TAG_HOLD   = 15;
	localparam int unsigned BUS_W         = 11;
	localparam int unsigned CYL_W         = 11;
	localparam int unsigned HEAD_W        = 8;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int unsigned ST_FAULT    = 0;
	localparam int unsigned ST_SEEK_ERR = 1;
	localparam int unsigned ST_ON_CYL   = 2;
	localparam int unsigned ST_READY    = 3;
	localparam int unsigned ST_AM_FOUND = 4;
	localparam int unsigned ST_WR_PROT  = 5;
	localparam int unsigned ST_BUSY     = 6;
	localparam int unsigned ST_SEEK_END = 7;
	localparam int unsigned ST_UNIT_SEL = 8;
	localparam int unsigned ST_RD_VALID = 9;
	localparam int unsigned ST_WR_FULL  = 10;
	localparam int unsigned ST_SECT_LO  = 16;

	localparam int unsigned WORD_W  = 16;
	localparam int unsigned SECT_W  = 8;
	localparam int unsigned PORTS   = 4;
endpackage

// ==== hdl/dci_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is independent; no multi-bit coherence is promised
`timescale 1ns/1ps
module dci_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_nrst,
	// levels
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			meta_r <= '0;
			o_q    <= '0;
		end else begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule

// ==== hdl/dci_ctrl.sv ====
// disk cable interface controller: shared control cable, four radial
// data links, per-drive sector counters, indicators, power sequencing
// assumes all cable inputs are asynchronous; i_nrst is the power-fail reset
//
// Notes on behaviour
// [RULE1] fault light steady until self-test passes
// [RULE2] blink fault light when no drive found
// [RULE3] activity light during disk read or write
// [RULE4] eleventh cylinder bit on bus bit 10
// [RULE5] tag 3 word: gates, clear, mark, release
// [RULE6] bits 2 and 3 give head offset
// [RULE7] bits 7 and 8 shift data strobe
// [RULE8] bit 6 returns heads to zero
// [RULE9] busy counts only for dual-port drives
// [RULE10] one shared cable, unit tag selects drive
// [RULE11] each drive has its own radial link
// [RULE12] per-drive sector counter, index realigns it
// [RULE13] pick and hold only outside power-fail reset
// [RULE14] all four radial ports behave identically
// [RULE15] selected drive status readable by sequencer
// [RULE16] read stream packed into 16-bit words
// [RULE17] write serialiser paced by drive servo clock
// [RULE18] cylinder on tag 1, head on tag 2
// [RULE19] read clock samples, write clock from servo
// [RULE20] drive answers only when its unit matches
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dci_ctrl #(
	parameter int unsigned BLINK_CYC = dci_pkg::BLINK_CYC,
	parameter int unsigned PORTS     = dci_pkg::PORTS
) (
	// clock and power-fail reset
	input  wire logic              i_clock,
	input  wire logic              i_nrst,
	// register port
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	// shared control cable, outgoing
	output logic                   o_unit_tag,
	output logic      [3:0]        o_unit_bits,
	output logic                   o_tag1,
	output logic                   o_tag2,
	output logic                   o_tag3,
	output logic      [10:0]       o_bus_bits,
	output logic                   o_open_cable,
	output logic                   o_pick,
	output logic                   o_hold,
	// shared control cable, status from selected drive
	input  wire logic              i_fault,
	input  wire logic              i_seek_err,
	input  wire logic              i_on_cyl,
	input  wire logic              i_unit_ready,
	input  wire logic              i_am_found,
	input  wire logic              i_busy,
	input  wire logic              i_wr_prot,
	// radial links, one bit per port
	input  wire logic [PORTS-1:0]  i_read_data,
	input  wire logic [PORTS-1:0]  i_read_clock,
	input  wire logic [PORTS-1:0]  i_servo_clock,
	input  wire logic [PORTS-1:0]  i_seek_end,
	input  wire logic [PORTS-1:0]  i_unit_selected,
	input  wire logic [PORTS-1:0]  i_index,
	input  wire logic [PORTS-1:0]  i_sector,
	output logic      [PORTS-1:0]  o_write_data,
	output logic      [PORTS-1:0]  o_write_clock,
	// indicators
	output logic                   o_fault_led,
	output logic                   o_activity_led
);
	localparam int unsigned SW = 7 + 7 * PORTS;
	localparam int unsigned BW = $clog2(BLINK_CYC + 1);
	localparam int unsigned WW = dci_pkg::WORD_W;

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	logic [SW-1:0]    sync_q;
	logic [SW-1:0]    prev_r;
	logic [6:0]       a_st;
	logic [PORTS-1:0] rd_d, rd_c, sv_c, sk_e, u_sel, idx, sec;
	logic [PORTS-1:0] rd_c_p, sv_c_p, idx_p, sec_p;

	dci_sync #(.W(SW)) u_sync (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_d     ({i_sector, i_index, i_unit_selected, i_seek_end, i_servo_clock,
		            i_read_clock, i_read_data, i_wr_prot, i_busy, i_am_found,
		            i_unit_ready, i_on_cyl, i_seek_err, i_fault}),
		.o_q     (sync_q)
	);

	// edges are found against a third stage, never the first flop
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			prev_r <= '0;
		end else begin
			prev_r <= sync_q;
		end
	end

	assign {sec, idx, u_sel, sk_e, sv_c, rd_c, rd_d, a_st} = sync_q;
	assign {sec_p, idx_p} = prev_r[SW-1 -: 2 * PORTS];
	assign sv_c_p = prev_r[7 + 2 * PORTS +: PORTS];
	assign rd_c_p = prev_r[7 + PORTS +: PORTS];

	function automatic logic rise(input logic cur, input logic old);
		return cur & ~old;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ------------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------------
	logic [dci_pkg::CFG_W-1:0]  cfg_r;
	logic [dci_pkg::SEL_W-1:0]  sel_r;
	logic [dci_pkg::CYL_W-1:0]  cyl_r;
	logic [dci_pkg::HEAD_W-1:0] head_r;
	logic [15:0]                ctlw_r;
	logic [1:0]                 port;
	logic                       wgate, rgate;

	assign port  = sel_r[dci_pkg::SEL_PORT_LO +: 2];
	assign wgate = ctlw_r[dci_pkg::CW_TAG_HOLD] & ctlw_r[dci_pkg::CW_WRITE_GATE];
	assign rgate = ctlw_r[dci_pkg::CW_TAG_HOLD] & ctlw_r[dci_pkg::CW_READ_GATE];

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			cfg_r  <= dci_pkg::CFG_RST;
			sel_r  <= '0;
			cyl_r  <= '0;
			head_r <= '0;
			ctlw_r <= '0;
		end else if (i_wr) begin
			if (hit(i_addr, dci_pkg::OFS_CFG)) begin
				cfg_r <= i_wdata[dci_pkg::CFG_W-1:0];
			end
			if (hit(i_addr, dci_pkg::OFS_SEL)) begin
				sel_r <= i_wdata[dci_pkg::SEL_W-1:0];
			end
			if (hit(i_addr, dci_pkg::OFS_CYL)) begin
				cyl_r <= i_wdata[dci_pkg::CYL_W-1:0]; // [RULE4]
			end
			if (hit(i_addr, dci_pkg::OFS_HEAD)) begin
				head_r <= i_wdata[dci_pkg::HEAD_W-1:0];
			end
			if (hit(i_addr, dci_pkg::OFS_CTLW)) begin
				ctlw_r <= i_wdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// tag strobes on the shared cable
	// ------------------------------------------------------------------
	logic [dci_pkg::TAG_CNT_W-1:0] ut_cnt_r, t1_cnt_r, t2_cnt_r;
	localparam logic [dci_pkg::TAG_CNT_W-1:0] TAG_LOAD = dci_pkg::TAG_CNT_W'(dci_pkg::TAG_CYC);

	// a write restarts the strobe so a new value gets a full tag, except a head tag cut short while tag 1 stands
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			ut_cnt_r <= '0;
			t1_cnt_r <= '0;
			t2_cnt_r <= '0;
		end else begin
			ut_cnt_r <= (i_wr && hit(i_addr, dci_pkg::OFS_SEL)) ? TAG_LOAD :
			            (ut_cnt_r != '0) ? ut_cnt_r - 1'b1 : ut_cnt_r; // [RULE10]
			t1_cnt_r <= (i_wr && hit(i_addr, dci_pkg::OFS_CYL)) ? TAG_LOAD :
			            (t1_cnt_r != '0) ? t1_cnt_r - 1'b1 : t1_cnt_r; // [RULE18]
			t2_cnt_r <= (i_wr && hit(i_addr, dci_pkg::OFS_HEAD)) ? TAG_LOAD :
			            (t2_cnt_r != '0) ? t2_cnt_r - 1'b1 : t2_cnt_r; // [RULE18]
		end
	end

	// address tags take the bus lines over tag 3 while they stand
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_unit_tag  <= 1'b0;
			o_unit_bits <= '0;
			o_tag1      <= 1'b0;
			o_tag2      <= 1'b0;
			o_tag3      <= 1'b0;
			o_bus_bits  <= '0;
		end else begin
			o_unit_tag  <= ut_cnt_r != '0; // [RULE10] [RULE20]
			o_unit_bits <= sel_r[3:0]; // [RULE10]
			o_tag1      <= t1_cnt_r != '0; // [RULE18]
			o_tag2      <= (t2_cnt_r != '0) && (t1_cnt_r == '0); // [RULE18]
			o_tag3      <= ctlw_r[dci_pkg::CW_TAG_HOLD] && (t1_cnt_r == '0) &&
			               (t2_cnt_r == '0);
			if (t1_cnt_r != '0) begin
				o_bus_bits <= cyl_r; // [RULE4] [RULE18]
			end else if (t2_cnt_r != '0) begin
				o_bus_bits <= dci_pkg::BUS_W'(head_r); // [RULE18]
			end else if (ctlw_r[dci_pkg::CW_TAG_HOLD]) begin
				// gates, offsets, strobes, return to zero, release
				o_bus_bits <= {1'b0, ctlw_r[9:0]}; // [RULE5] [RULE6] [RULE7] [RULE8]
			end else begin
				o_bus_bits <= '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// power sequencing and indicators
	// ------------------------------------------------------------------
	logic [BW-1:0] blink_cnt_r;
	logic          blink_r;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_pick       <= 1'b0;
			o_hold       <= 1'b0;
			o_open_cable <= 1'b0;
		end else begin
			o_pick       <= 1'b1; // [RULE13]
			o_hold       <= 1'b1; // [RULE13]
			o_open_cable <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r == BW'(BLINK_CYC - 1)) begin
			blink_cnt_r <= '0;
			blink_r     <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_fault_led    <= 1'b1;
			o_activity_led <= 1'b0;
		end else begin
			if (!cfg_r[dci_pkg::CFG_TEST_DONE] || !cfg_r[dci_pkg::CFG_TEST_OK]) begin
				o_fault_led <= 1'b1; // [RULE1]
			end else if (!cfg_r[dci_pkg::CFG_DRV_FOUND]) begin
				o_fault_led <= blink_r; // [RULE2]
			end else begin
				o_fault_led <= 1'b0;
			end
			o_activity_led <= wgate | rgate; // [RULE3]
		end
	end

	// ------------------------------------------------------------------
	// per-port sector counters
	// ------------------------------------------------------------------
	logic [dci_pkg::SECT_W-1:0] sect_r [PORTS];

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			for (int p = 0; p < PORTS; p++) begin
				sect_r[p] <= '0;
			end
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				if (rise(idx[p], idx_p[p])) begin
					sect_r[p] <= '0; // [RULE12] [RULE14]
				end else if (rise(sec[p], sec_p[p])) begin
					sect_r[p] <= sect_r[p] + 1'b1; // [RULE12]
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// read deserialiser on the selected port
	// ------------------------------------------------------------------
	logic [WW-1:0] rd_sh_r, rd_word_r;
	logic [3:0]    rd_cnt_r;
	logic          rd_valid_r, rd_edge, rd_take;

	assign rd_edge = rgate && rise(rd_c[port], rd_c_p[port]); // [RULE19]
	assign rd_take = i_rd && hit(i_addr, dci_pkg::OFS_RDWORD);

	always_ff @(posedge i_clock) begin
		if (!i_nrst || !rgate) begin
			rd_sh_r  <= '0;
			rd_cnt_r <= '0;
		end else if (rd_edge) begin
			rd_sh_r  <= {rd_sh_r[WW-2:0], rd_d[port]}; // [RULE16] [RULE11]
			rd_cnt_r <= rd_cnt_r + 1'b1;
		end
	end

	// a word completing in the same cycle as a read still sets valid
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			rd_word_r  <= '0;
			rd_valid_r <= 1'b0;
		end else if (rd_edge && rd_cnt_r == 4'hF) begin
			rd_word_r  <= {rd_sh_r[WW-2:0], rd_d[port]}; // [RULE16]
			rd_valid_r <= 1'b1;
		end else if (rd_take) begin
			rd_valid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// write serialiser on the selected port, paced by servo clock
	// ------------------------------------------------------------------
	logic [WW-1:0] wr_hold_r, wr_sh_r, wr_src;
	logic [3:0]    wr_cnt_r;
	logic          wr_full_r, sv_edge, wr_load;

	assign sv_edge = wgate && rise(sv_c[port], sv_c_p[port]); // [RULE17]
	assign wr_load = sv_edge && (wr_cnt_r == 4'h0);
	// an empty holding word sends zeros rather than stalling the disk
	assign wr_src  = (wr_cnt_r == 4'h0) ? (wr_full_r ? wr_hold_r : '0) : wr_sh_r;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			wr_hold_r <= '0;
			wr_full_r <= 1'b0;
		end else if (i_wr && hit(i_addr, dci_pkg::OFS_WRWORD)) begin
			wr_hold_r <= i_wdata[WW-1:0];
			wr_full_r <= 1'b1;
		end else if (wr_load) begin
			wr_full_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst || !wgate) begin
			wr_sh_r  <= '0;
			wr_cnt_r <= '0;
		end else if (sv_edge) begin
			wr_sh_r  <= {wr_src[WW-2:0], 1'b0}; // [RULE17]
			wr_cnt_r <= wr_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_write_data  <= '0;
			o_write_clock <= '0;
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				if (wgate && port == 2'(p)) begin
					if (sv_edge) begin
						o_write_data[p] <= wr_src[WW-1]; // [RULE11] [RULE14]
					end
					o_write_clock[p] <= sv_c[p]; // [RULE19]
				end else begin
					o_write_data[p]  <= 1'b0;
					o_write_clock[p] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// read data path
	// ------------------------------------------------------------------
	logic [31:0] stat;

	always_comb begin
		stat = '0;
		stat[dci_pkg::ST_FAULT]    = a_st[0]; // [RULE15]
		stat[dci_pkg::ST_SEEK_ERR] = a_st[1];
		stat[dci_pkg::ST_ON_CYL]   = a_st[2];
		stat[dci_pkg::ST_READY]    = a_st[3];
		stat[dci_pkg::ST_AM_FOUND] = a_st[4];
		stat[dci_pkg::ST_BUSY]     = a_st[5] & cfg_r[dci_pkg::CFG_DUAL_PORT]; // [RULE9]
		stat[dci_pkg::ST_WR_PROT]  = a_st[6];
		stat[dci_pkg::ST_SEEK_END] = sk_e[port]; // [RULE11]
		stat[dci_pkg::ST_UNIT_SEL] = u_sel[port];
		stat[dci_pkg::ST_RD_VALID] = rd_valid_r;
		stat[dci_pkg::ST_WR_FULL]  = wr_full_r;
		stat[dci_pkg::ST_SECT_LO +: dci_pkg::SECT_W] = sect_r[port];
	end

	// unmapped addresses read as zero
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			unique case (i_addr)
				dci_pkg::OFS_CFG:    o_rdata <= 32'(cfg_r);
				dci_pkg::OFS_SEL:    o_rdata <= 32'(sel_r);
				dci_pkg::OFS_CYL:    o_rdata <= 32'(cyl_r);
				dci_pkg::OFS_HEAD:   o_rdata <= 32'(head_r);
				dci_pkg::OFS_CTLW:   o_rdata <= 32'(ctlw_r);
				dci_pkg::OFS_STAT:   o_rdata <= stat;
				dci_pkg::OFS_RDWORD: o_rdata <= 32'(rd_word_r);
				dci_pkg::OFS_WRWORD: o_rdata <= 32'(wr_hold_r);
				dci_pkg::OFS_SECT:   o_rdata <= {sect_r[3], sect_r[2], sect_r[1], sect_r[0]};
				default:             o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end
endmodule

// ==== bench/dci_monitor.sv ====
// assertions on the shared cable, power sequencing and indicators
// assumes it is bound to dci_ctrl and sees only that module's ports
`timescale 1ns/1ps
module dci_monitor (
	// clock and reset
	input wire logic        i_clock,
	input wire logic        i_nrst,
	// register port
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	// cable and indicators
	input wire logic        o_unit_tag,
	input wire logic [3:0]  o_unit_bits,
	input wire logic        o_tag1,
	input wire logic        o_tag2,
	input wire logic        o_tag3,
	input wire logic [10:0] o_bus_bits,
	input wire logic        o_pick,
	input wire logic        o_hold,
	input wire logic        o_fault_led,
	input wire logic        o_activity_led
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	logic [10:0] wd;
	assign wd = i_wdata[10:0];
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	property p_pick;
		i_nrst |=> o_pick && o_hold;
	endproperty
	a_pick: assert property (p_pick) else $error("pick or hold low out of reset");
	property p_fault;
		$rose(i_nrst) |-> o_fault_led;
	endproperty
	a_fault: assert property (p_fault) else $error("fault light dark before test");
	property p_sel;
		(i_wr && i_addr == dci_pkg::OFS_SEL) |->
			##2 o_unit_tag && ({7'h00, o_unit_bits} == ($past(wd, 2) & 11'h00F));
	endproperty
	a_sel: assert property (p_sel) else $error("unit select wrong");
	property p_cyl;
		(i_wr && i_addr == dci_pkg::OFS_CYL) |-> ##2 o_tag1 && o_bus_bits == $past(wd, 2);
	endproperty
	a_cyl: assert property (p_cyl) else $error("cylinder tag wrong");
	property p_head;
		(i_wr && i_addr == dci_pkg::OFS_HEAD) |->
			##2 o_tag1 || (o_tag2 && o_bus_bits == ($past(wd, 2) & 11'h0FF));
	endproperty
	a_head: assert property (p_head) else $error("head tag wrong");
	property p_tag1_len;
		$rose(o_tag1) |-> o_tag1[*8] ##1 o_tag1[*8] ##1 o_tag1[*4] ##1 !o_tag1;
	endproperty
	a_tag1_len: assert property (p_tag1_len) else $error("cylinder tag length");
	property p_ctl;
		(i_wr && i_addr == dci_pkg::OFS_CTLW && i_wdata[15]) |->
			##2 o_tag1 || o_tag2 || (o_tag3 && o_bus_bits == ($past(wd, 2) & 11'h3FF));
	endproperty
	a_ctl: assert property (p_ctl) else $error("control word wrong");
	property p_act;
		o_tag3 |-> o_activity_led == (o_bus_bits[1:0] != 2'b00);
	endproperty
	a_act: assert property (p_act) else $error("activity light wrong");

	c_sel: cover property (o_unit_tag && o_unit_bits == 4'h2);
	c_rd: cover property (o_tag3 && o_bus_bits[1]);
	c_wr: cover property (o_tag3 && o_bus_bits[0]);
endmodule

// ==== bench/dci_drive_model.sv ====
// behavioural model of four drives on the shared and radial cables
// assumes drive k sits on radial port k and answers to unit number k
`timescale 1ns/1ps
module dci_drive_model (
	// shared cable from the controller
	input  wire logic       i_unit_tag,
	input  wire logic [3:0] i_unit_bits,
	// radial links
	input  wire logic [3:0] i_write_data,
	output logic      [3:0] o_read_data,
	output logic      [3:0] o_read_clock,
	output logic      [3:0] o_servo_clock,
	output logic      [3:0] o_index,
	output logic      [3:0] o_sector,
	output logic      [3:0] o_seek_end,
	output logic      [3:0] o_unit_selected,
	// status of the selected drive
	output logic      [6:0] o_status
);
	logic [6:0] stat   = 7'h00;
	logic [3:0] unit_r = 4'hF;
	logic       here;
	initial begin
		o_read_data   = 4'h0;
		o_read_clock  = 4'h0;
		o_servo_clock = 4'h0;
		o_index       = 4'h0;
		o_sector      = 4'h0;
	end
	always @(i_unit_tag or i_unit_bits) begin
		if (i_unit_tag) begin
			unit_r = i_unit_bits;
		end
	end
	// terminated lines read low when no drive answers
	assign here            = (unit_r < 4'h4);
	assign o_status        = here ? stat : 7'h00;
	assign o_unit_selected = here ? (4'h1 << unit_r[1:0]) : 4'h0;
	assign o_seek_end      = stat[2] ? o_unit_selected : 4'h0;

	// clocks stand still outside frames; odd offset keeps phase unrelated
	task automatic send(input int p, input logic [15:0] w);
		#7;
		for (int i = 15; i >= 0; i--) begin
			o_read_data[p] = w[i];
			#200 o_read_clock[p] = 1'b1;
			#200 o_read_clock[p] = 1'b0;
		end
		o_read_data[p] = 1'b0;
	endtask
	task automatic xmit(input int p, output logic [15:0] w);
		#7;
		for (int i = 0; i < 16; i++) begin
			o_servo_clock[p] = 1'b1;
			#200 o_servo_clock[p] = 1'b0;
			#190 w = {w[14:0], i_write_data[p]};
			#10;
		end
	endtask
	task automatic pulse(input int p, input logic ix);
		o_index[p]  = ix;
		o_sector[p] = !ix;
		#200;
		o_index[p]  = 1'b0;
		o_sector[p] = 1'b0;
		#200;
	endtask
endmodule

// ==== bench/test_disk_drive_cable_interface.sv ====
// self-checking bench for the disk cable interface controller
// assumes the drive model plays all four drives on both cables
`timescale 1ns/1ps
module test_disk_drive_cable_interface;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        i_clock = 1'b0;
	logic        i_nrst  = 1'b0;
	logic [7:0]  i_addr  = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr    = 1'b0;
	logic        i_rd    = 1'b0;
	logic [31:0] o_rdata, v;
	logic        o_unit_tag, o_tag1, o_tag2, o_tag3, o_open_cable, o_pick, o_hold;
	logic        o_fault_led, o_activity_led;
	logic [3:0]  o_unit_bits, o_write_data, o_write_clock;
	logic [3:0]  i_read_data, i_read_clock, i_servo_clock, i_seek_end;
	logic [3:0]  i_unit_selected, i_index, i_sector;
	logic [10:0] o_bus_bits;
	logic [6:0]  st;
	logic [15:0] w;
	int          n_fail  = 0;
	int          checked = 0;
	int          nwc     = 0;
	int          tg;
	always #25 i_clock = ~i_clock;
	always @(posedge o_write_clock[3]) nwc++;

	dci_ctrl #(.BLINK_CYC(4)) u_dut (
		.i_clock, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.o_unit_tag, .o_unit_bits, .o_tag1, .o_tag2, .o_tag3, .o_bus_bits,
		.o_open_cable, .o_pick, .o_hold, .i_fault(st[0]), .i_seek_err(st[1]),
		.i_on_cyl(st[2]), .i_unit_ready(st[3]), .i_am_found(st[4]), .i_wr_prot(st[5]),
		.i_busy(st[6]), .i_read_data, .i_read_clock, .i_servo_clock, .i_seek_end,
		.i_unit_selected, .i_index, .i_sector, .o_write_data, .o_write_clock,
		.o_fault_led, .o_activity_led
	);
	dci_drive_model u_drv (
		.i_unit_tag(o_unit_tag), .i_unit_bits(o_unit_bits), .i_write_data(o_write_data),
		.o_read_data(i_read_data), .o_read_clock(i_read_clock), .o_index(i_index),
		.o_servo_clock(i_servo_clock), .o_sector(i_sector), .o_seek_end(i_seek_end),
		.o_unit_selected(i_unit_selected), .o_status(st)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		v = o_rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		@(negedge i_clock);
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		settle(4);
		chk("pick", {o_pick, o_hold, o_open_cable}, 3'b000);
		@(posedge i_clock);
		i_nrst <= 1'b1;
		settle(1);
		chk("pick", {o_pick, o_hold, o_open_cable}, 3'b111);
		wr(dci_pkg::OFS_CFG, 32'h1);
		settle(2);
		chk("fault", o_fault_led, 1'b1);
		wr(dci_pkg::OFS_CFG, 32'h7);
		settle(2);
		chk("fault", o_fault_led, 1'b0);
		wr(dci_pkg::OFS_CFG, 32'h3);
		settle(2);
		tg = 0;
		repeat (40) begin
			w[0] = o_fault_led;
			settle(1);
			tg += (o_fault_led !== w[0]);
		end
		chk("blink", tg >= 9, 1'b1);
		$display("test indicators done");
		wr(dci_pkg::OFS_SEL, 32'h22);
		settle(1);
		chk("unit", {o_unit_tag, o_unit_bits}, 5'h12);
		settle(21);
		wr(dci_pkg::OFS_CYL, 32'h4A5);
		settle(1);
		chk("cyl", {o_tag1, o_bus_bits}, 12'hCA5);
		settle(21);
		wr(dci_pkg::OFS_HEAD, 32'hC3);
		settle(1);
		chk("head", {o_tag2, o_bus_bits}, 12'h8C3);
		settle(21);
		for (int b = 0; b < 10; b++) begin
			wr(dci_pkg::OFS_CTLW, 32'h8000 | (32'h1 << b));
			settle(1);
			chk("ctl", {o_tag3, o_bus_bits}, 12'h800 | (12'h1 << b));
			chk("act", o_activity_led, b < 2);
		end
		wr(dci_pkg::OFS_CTLW, 32'h0);
		$display("test control cable done");
		u_drv.stat = 7'h7F;
		settle(4);
		rd(dci_pkg::OFS_STAT);
		chk("stat", v[8:0], 9'h1BF);
		wr(dci_pkg::OFS_CFG, 32'hF);
		rd(dci_pkg::OFS_STAT);
		chk("stat", v[8:0], 9'h1FF);
		wr(dci_pkg::OFS_SEL, 32'h25);
		settle(4);
		rd(dci_pkg::OFS_STAT);
		chk("stat", v[8:0], 9'h000);
		rd(8'hFC);
		chk("unmapped", v, 32'h0);
		$display("test status done");
		for (int p = 0; p < 4; p++) begin
			wr(dci_pkg::OFS_SEL, 32'h11 * p);
			settle(21);
			wr(dci_pkg::OFS_CTLW, 32'h8002);
			u_drv.send(p, 16'hB38E ^ 16'(p));
			settle(6);
			rd(dci_pkg::OFS_RDWORD);
			chk("rword", v[15:0], 16'hB38E ^ 16'(p));
			wr(dci_pkg::OFS_CTLW, 32'h0);
		end
		wr(dci_pkg::OFS_WRWORD, 32'h9C31);
		wr(dci_pkg::OFS_CTLW, 32'h8001);
		u_drv.xmit(3, w);
		chk("wword", w, 16'h9C31);
		chk("wclk", nwc, 16);
		wr(dci_pkg::OFS_CTLW, 32'h0);
		$display("test data links done");
		for (int p = 0; p < 4; p++) begin
			repeat (5) u_drv.pulse(p, 1'b0);
			u_drv.pulse(p, 1'b1);
			repeat (p + 2) u_drv.pulse(p, 1'b0);
		end
		settle(4);
		rd(dci_pkg::OFS_SECT);
		chk("sect", v, 32'h05040302);
		$display("test sector counters done");
		give_verdict();
	end

	// the whole sequence needs well under 200 us
	initial begin
		#500000;
		n_fail++;
		give_verdict();
	end
endmodule

bind dci_ctrl dci_monitor u_mon (
	.i_clock, .i_nrst, .i_addr, .i_wdata, .i_wr, .o_unit_tag, .o_unit_bits, .o_tag1,
	.o_tag2, .o_tag3, .o_bus_bits, .o_pick, .o_hold, .o_fault_led, .o_activity_led
);
